/* bench/cct_reflex_sink.sv */
`timescale 1ns/10ps
// far-side consumer: tallies the pulses arriving over the event network
module cct_reflex_sink #(
  parameter int unsigned CHANNELS = 4
) (
  // clock and reset
  input  wire logic                mclk,
  input  wire logic                rst_n,
  // event network
  input  wire logic [CHANNELS-1:0] reflexTrigger,
  input  wire logic                reflexOverflow,
  // tallies
  output logic      [15:0]         trigCount,
  output logic      [15:0]         ovfCount
);
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      trigCount <= 16'h0000;
      ovfCount  <= 16'h0000;
    end else begin
      trigCount <= trigCount + 16'($countones(reflexTrigger));
      ovfCount  <= ovfCount + {15'h0000, reflexOverflow};
    end
  end
endmodule

/* bench/testbench.sv */
`timescale 1ns/10ps
module testbench;
  logic                     mclk, rst_n, countEnable, eventPin, overflowClear, deadTimeEnable;
  cct_pkg::cct_src_e        countSource;
  cct_pkg::cct_mode_e [3:0] chanMode;
  logic [3:0][15:0]         compareValue, captureValue;
  logic [3:0]               compareWrite, captureRise, capturePin, captureValid;
  logic [3:0]               chanOut, chanOutN, reflexTrigger;
  logic [7:0]               deadTime;
  logic [15:0]              counterValue, trigCount, ovfCount;
  logic                     overflowFlag, reflexOverflow;
  logic [3:0][31:0]         compareWide, captureWide;
  logic [31:0]              counterWide;
  logic                     overflowWide;
  int                       failures, checked;

  cct_timer #(.WIDTH(16), .CHANNELS(4), .INSTANCE(0)) DUT (
    .mclk(mclk), .rst_n(rst_n), .countEnable(countEnable), .countSource(countSource),
    .eventPin(eventPin), .overflowClear(overflowClear), .chanMode(chanMode),
    .compareValue(compareValue), .compareWrite(compareWrite), .captureRise(captureRise),
    .capturePin(capturePin), .deadTimeEnable(deadTimeEnable), .deadTime(deadTime),
    .counterValue(counterValue), .overflowFlag(overflowFlag), .captureValue(captureValue),
    .captureValid(captureValid), .chanOut(chanOut), .chanOutN(chanOutN),
    .reflexTrigger(reflexTrigger), .reflexOverflow(reflexOverflow));

  // wide unit without dead time, fed the same stimulus
  assign compareWide = {{16'h0000, compareValue[3]}, {16'h0000, compareValue[2]},
                        {16'h0000, compareValue[1]}, {16'h0000, compareValue[0]}};

  cct_timer #(.WIDTH(32), .CHANNELS(4), .INSTANCE(1)) DUT_wide (
    .mclk(mclk), .rst_n(rst_n), .countEnable(countEnable), .countSource(countSource),
    .eventPin(eventPin), .overflowClear(overflowClear), .chanMode(chanMode),
    .compareValue(compareWide), .compareWrite(compareWrite), .captureRise(captureRise),
    .capturePin(capturePin), .deadTimeEnable(deadTimeEnable), .deadTime(deadTime),
    .counterValue(counterWide), .overflowFlag(overflowWide), .captureValue(captureWide),
    .captureValid(), .chanOut(), .chanOutN(), .reflexTrigger(), .reflexOverflow());

  cct_reflex_sink #(.CHANNELS(4)) sink (.mclk(mclk), .rst_n(rst_n),
    .reflexTrigger(reflexTrigger), .reflexOverflow(reflexOverflow),
    .trigCount(trigCount), .ovfCount(ovfCount));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // bounded wait, sampled where outputs are settled
  task automatic wait_for(input int which, input logic [15:0] v);
    int i;
    for (i = 0; i < 70000; i++) begin
      @(negedge mclk);
      if (which == 0 && counterValue === v) break;
      if (which == 1 && reflexTrigger[0] === 1'b1) break;
      if (which == 2 && reflexOverflow === 1'b1) break;
    end
    if (i == 70000) failures++;
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic test_count();
    @(posedge mclk) countEnable <= 1'b1;
    tick(50);
    countEnable <= 1'b0;
    @(negedge mclk);
    chk(counterValue, 32'h0000_0032);
    chk(counterWide, 32'h0000_0032);
    $display("test count done");
  endtask

  task automatic test_compare();
    @(posedge mclk) chanMode[0] <= cct_pkg::CCT_MODE_COMPARE;
    compareValue[0] <= 16'h0046;
    compareWrite[0] <= 1'b1;
    @(posedge mclk) compareWrite[0] <= 1'b0;
    countEnable <= 1'b1;
    tick(1);
    @(negedge mclk);
    chk(chanOut[0], 1'b0);
    wait_for(1, 16'h0000);
    chk(counterValue, 32'h0000_0047);
    chk(chanOut[0], 1'b1);
    @(posedge mclk) countEnable <= 1'b0;
    @(negedge mclk);
    chk(trigCount, 32'h0000_0001);
    $display("test compare done");
  endtask

  task automatic test_capture();
    @(posedge mclk) chanMode[1] <= cct_pkg::CCT_MODE_CAPTURE;
    chanMode[2]    <= cct_pkg::CCT_MODE_CAPTURE;
    captureRise    <= 4'h2;
    capturePin[2]  <= 1'b1;
    tick(8);
    capturePin[1]  <= 1'b1;
    capturePin[2]  <= 1'b0;
    tick(5);
    @(negedge mclk);
    chk(captureValid, 32'h0000_0006);
    @(negedge mclk);
    chk(captureValid, 32'h0000_0000);
    chk(captureValue[1], 32'h0000_0048);
    chk(captureWide[1], 32'h0000_0048);
    chk(captureValue[2], 32'h0000_0048);
    chk(captureValue[0], 32'h0000_0000);
    chk(trigCount, 32'h0000_0003);
    $display("test capture done");
  endtask

  task automatic test_events();
    @(posedge mclk) countSource <= cct_pkg::CCT_SRC_EVENT;
    countEnable <= 1'b1;
    repeat (3) begin
      eventPin <= 1'b1;
      tick(8);
      eventPin <= 1'b0;
      tick(8);
    end
    countEnable <= 1'b0;
    countSource <= cct_pkg::CCT_SRC_CLOCK;
    @(negedge mclk);
    chk(counterValue, 32'h0000_004B);
    $display("test events done");
  endtask

  task automatic test_wrap_pwm();
    @(posedge mclk) chanMode[3] <= cct_pkg::CCT_MODE_PWM;
    compareValue[3] <= 16'h0064;
    compareWrite[3] <= 1'b1;
    @(posedge mclk) compareWrite[3] <= 1'b0;
    countEnable <= 1'b1;
    wait_for(2, 16'h0000);
    @(negedge mclk);
    chk(overflowFlag, 1'b1);
    chk(chanOut[3], 1'b0);
    chk(chanOutN[3], 1'b0);
    wait_for(0, 16'h000A);
    chk(chanOut[3], 1'b1);
    chk(chanOutN[3], 1'b0);
    wait_for(0, 16'h0078);
    chk(chanOut[3], 1'b0);
    chk(chanOutN[3], 1'b1);
    @(posedge mclk) overflowClear <= 1'b1;
    @(posedge mclk) overflowClear <= 1'b0;
    @(negedge mclk);
    chk(overflowFlag, 1'b0);
    chk(ovfCount, 32'h0000_0001);
    chk(counterValue, 32'h0000_007A);
    chk(counterWide, 32'h0001_007A);
    chk(overflowWide, 1'b0);
    $display("test wrap and pwm done");
  endtask

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  initial begin
    repeat (75000) @(posedge mclk);
    failures++;
    tally_and_finish();
  end

  initial begin
    failures = 0;
    checked = 0;
    rst_n = 1'b0;
    countEnable = 1'b0;
    countSource = cct_pkg::CCT_SRC_CLOCK;
    eventPin = 1'b0;
    overflowClear = 1'b0;
    foreach (chanMode[i]) chanMode[i] = cct_pkg::CCT_MODE_OFF;
    compareValue = '0;
    compareWrite = 4'h0;
    captureRise = 4'h0;
    capturePin = 4'h0;
    deadTimeEnable = 1'b1;
    deadTime = 8'h03;
    tick(10);
    rst_n <= 1'b1;
    @(negedge mclk);
    chk(counterValue, 32'h0000_0000);
    test_count();
    test_compare();
    test_capture();
    test_events();
    test_wrap_pwm();
    tally_and_finish();
  end
endmodule

/* logic/cct_pkg.sv */
package cct_pkg;
  localparam int unsigned NUM_CHANNELS     = 4;
  localparam int unsigned STD_WIDTH        = 16;
  localparam int unsigned WIDE_WIDTH       = 32;
  localparam int unsigned DEAD_TIME_W      = 8;
  localparam int unsigned SYNC_STAGES      = 3;

  typedef enum logic [1:0] {
    CCT_MODE_OFF,
    CCT_MODE_CAPTURE,
    CCT_MODE_COMPARE,
    CCT_MODE_PWM
  } cct_mode_e;

  typedef enum logic {
    CCT_SRC_CLOCK,
    CCT_SRC_EVENT
  } cct_src_e;
endpackage

/* logic/cct_sync.sv */
`timescale 1ns/10ps
// three-stage input synchroniser; a change is taken once stages two and three agree
module cct_sync #(
  parameter int unsigned WIDTH = 1
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             rst_n,
  // data
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] st1_q;
  logic [WIDTH-1:0] st2_q;
  logic [WIDTH-1:0] st3_q;
  logic [WIDTH-1:0] out_q;
  logic [WIDTH-1:0] out_d;

  always_comb begin
    out_d = out_q;
    for (int i = 0; i < WIDTH; i++) begin
      if (st2_q[i] == st3_q[i]) begin
        out_d[i] = st3_q[i];
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st1_q <= '0;
      st2_q <= '0;
      st3_q <= '0;
      out_q <= '0;
    end else begin
      st1_q <= asyncIn;
      st2_q <= st1_q;
      st3_q <= st2_q;
      out_q <= out_d;
    end
  end

  assign syncOut = out_q;
endmodule

/* logic/cct_timer.sv */
`timescale 1ns/10ps
// Operation
// - standard unit uses a sixteen-bit counter
// - wide unit uses a thirty-two-bit counter
// - wide unit differs from standard in counter width and, as instance one, has no dead time
// - up to four channels, each capture or compare capable
// - each channel runs in exactly one mode: off, capture, compare or pwm
// - capture copies counter into channel buffer on selected input event
// - compare output shows counter compared against programmed threshold
// - pwm output follows successive compare values software writes
// - dead-time insertion exists only in instance zero
// - counts clock or external events and produces pwm outputs
// - drives timed trigger pulses to the reflex event network
module cct_timer #(
  parameter int unsigned WIDTH    = cct_pkg::STD_WIDTH,
  parameter int unsigned CHANNELS = cct_pkg::NUM_CHANNELS,
  parameter int unsigned INSTANCE = 0
) (
  // clock and reset
  input  wire logic                                 mclk,
  input  wire logic                                 rst_n,
  // counter control
  input  wire logic                                 countEnable,
  input  wire cct_pkg::cct_src_e                    countSource,
  input  wire logic                                 eventPin,
  input  wire logic                                 overflowClear,
  // channel configuration
  input  wire cct_pkg::cct_mode_e [CHANNELS-1:0]    chanMode,
  input  wire logic [CHANNELS-1:0][WIDTH-1:0]       compareValue,
  input  wire logic [CHANNELS-1:0]                  compareWrite,
  input  wire logic [CHANNELS-1:0]                  captureRise,
  input  wire logic [CHANNELS-1:0]                  capturePin,
  // dead time
  input  wire logic                                 deadTimeEnable,
  input  wire logic [cct_pkg::DEAD_TIME_W-1:0]      deadTime,
  // status and outputs
  output logic [WIDTH-1:0]                          counterValue,
  output logic                                      overflowFlag,
  output logic [CHANNELS-1:0][WIDTH-1:0]            captureValue,
  output logic [CHANNELS-1:0]                       captureValid,
  output logic [CHANNELS-1:0]                       chanOut,
  output logic [CHANNELS-1:0]                       chanOutN,
  output logic [CHANNELS-1:0]                       reflexTrigger,
  output logic                                      reflexOverflow
);
  localparam logic [WIDTH-1:0] CNT_MAX = '1;
  localparam bit HAS_DEAD = (INSTANCE == 0);

  // refuse widths and channel counts the logic cannot serve
  if (WIDTH != cct_pkg::STD_WIDTH && WIDTH != cct_pkg::WIDE_WIDTH) begin : g_bad_width
    $error("width must be 16 or 32");
  end
  if (CHANNELS < 1 || CHANNELS > cct_pkg::NUM_CHANNELS) begin : g_bad_chan
    $error("channel count must be 1 to 4");
  end

  // pin synchronisation
  logic [CHANNELS:0] pinSync;
  cct_sync #(.WIDTH(CHANNELS + 1)) u_sync (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .asyncIn ({eventPin, capturePin}),
    .syncOut (pinSync)
  );

  // counter state
  logic [WIDTH-1:0]    cnt_q, cnt_d;
  logic                ovf_q, ovf_d;
  logic                ovfPulse_q, ovfPulse_d;
  logic                evtPrev_q, evtPrev_d;
  logic [CHANNELS-1:0] capPrev_q, capPrev_d;
  logic                tick;
  logic                wrap;

  assign tick = countEnable && ((countSource == cct_pkg::CCT_SRC_CLOCK) ||
                (pinSync[CHANNELS] && !evtPrev_q));
  assign wrap = tick && (cnt_q == CNT_MAX);

  always_comb begin
    evtPrev_d  = pinSync[CHANNELS];
    capPrev_d  = pinSync[CHANNELS-1:0];
    cnt_d      = tick ? cnt_q + 1'b1 : cnt_q;
    ovfPulse_d = wrap;
    ovf_d      = wrap ? 1'b1 : (overflowClear ? 1'b0 : ovf_q);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q      <= '0;
      ovf_q      <= 1'b0;
      ovfPulse_q <= 1'b0;
      evtPrev_q  <= 1'b0;
      capPrev_q  <= '0;
    end else begin
      cnt_q      <= cnt_d;
      ovf_q      <= ovf_d;
      ovfPulse_q <= ovfPulse_d;
      evtPrev_q  <= evtPrev_d;
      capPrev_q  <= capPrev_d;
    end
  end

  // channels
  logic [CHANNELS-1:0][WIDTH-1:0]              thr_q, thr_d;
  logic [CHANNELS-1:0][WIDTH-1:0]              cap_q, cap_d;
  logic [CHANNELS-1:0]                         capV_q, capV_d;
  logic [CHANNELS-1:0]                         raw_q, raw_d;
  logic [CHANNELS-1:0]                         out_q, out_d;
  logic [CHANNELS-1:0]                         outN_q, outN_d;
  logic [CHANNELS-1:0]                         trg_q, trg_d;
  logic [CHANNELS-1:0][cct_pkg::DEAD_TIME_W-1:0] dly_q, dly_d;

  function automatic logic capEdge(input logic cur, input logic prev, input logic rise);
    capEdge = rise ? (cur && !prev) : (!cur && prev);
  endfunction

  generate
    for (genvar c = 0; c < CHANNELS; c++) begin : g_chan
      logic match;
      logic useDead;
      assign match   = tick && (cnt_q == thr_q[c]);
      assign useDead = HAS_DEAD && deadTimeEnable;

      always_comb begin
        thr_d[c]  = thr_q[c];
        cap_d[c]  = cap_q[c];
        capV_d[c] = 1'b0;
        raw_d[c]  = raw_q[c];
        trg_d[c]  = 1'b0;
        dly_d[c]  = dly_q[c];
        out_d[c]  = out_q[c];
        outN_d[c] = outN_q[c];
        if (compareWrite[c]) begin
          thr_d[c] = compareValue[c];
        end
        unique case (chanMode[c])
          cct_pkg::CCT_MODE_CAPTURE: begin
            raw_d[c] = 1'b0;
            if (capEdge(pinSync[c], capPrev_q[c], captureRise[c])) begin
              cap_d[c]  = cnt_q;
              capV_d[c] = 1'b1;
              trg_d[c]  = 1'b1;
            end
          end
          cct_pkg::CCT_MODE_COMPARE: begin
            raw_d[c] = (cnt_q >= thr_q[c]);
            trg_d[c] = match;
          end
          cct_pkg::CCT_MODE_PWM: begin
            if (wrap) begin
              raw_d[c] = 1'b1;
            end else if (match) begin
              raw_d[c] = 1'b0;
            end
            trg_d[c] = match;
          end
          cct_pkg::CCT_MODE_OFF: begin
            raw_d[c] = 1'b0;
          end
        endcase
        if (useDead && chanMode[c] == cct_pkg::CCT_MODE_PWM) begin
          if (raw_d[c] != raw_q[c]) begin
            dly_d[c]  = deadTime;
            out_d[c]  = 1'b0;
            outN_d[c] = 1'b0;
          end else if (dly_q[c] != '0) begin
            dly_d[c] = dly_q[c] - 1'b1;
          end else begin
            out_d[c]  = raw_q[c];
            outN_d[c] = !raw_q[c];
          end
        end else begin
          dly_d[c]  = '0;
          out_d[c]  = raw_d[c];
          outN_d[c] = !raw_d[c];
        end
      end

      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          thr_q[c]  <= '0;
          cap_q[c]  <= '0;
          capV_q[c] <= 1'b0;
          raw_q[c]  <= 1'b0;
          trg_q[c]  <= 1'b0;
          dly_q[c]  <= '0;
          out_q[c]  <= 1'b0;
          outN_q[c] <= 1'b0;
        end else begin
          thr_q[c]  <= thr_d[c];
          cap_q[c]  <= cap_d[c];
          capV_q[c] <= capV_d[c];
          raw_q[c]  <= raw_d[c];
          trg_q[c]  <= trg_d[c];
          dly_q[c]  <= dly_d[c];
          out_q[c]  <= out_d[c];
          outN_q[c] <= outN_d[c];
        end
      end

      property p_capture;
        @(posedge mclk) disable iff (!rst_n)
        (chanMode[c] == cct_pkg::CCT_MODE_CAPTURE &&
         capEdge(pinSync[c], capPrev_q[c], captureRise[c]))
        |=> (cap_q[c] == $past(cnt_q)) && capV_q[c];
      endproperty
      a_capture: assert property (p_capture) else $error("capture lost");

      property p_compare;
        @(posedge mclk) disable iff (!rst_n)
        chanMode[c] == cct_pkg::CCT_MODE_COMPARE |=>
          raw_q[c] == ($past(cnt_q) >= $past(thr_q[c]));
      endproperty
      a_compare: assert property (p_compare) else $error("compare wrong");

      property p_pwm_low;
        @(posedge mclk) disable iff (!rst_n)
        (chanMode[c] == cct_pkg::CCT_MODE_PWM && match && !wrap) |=> !raw_q[c];
      endproperty
      a_pwm_low: assert property (p_pwm_low) else $error("pwm not low at match");

      property p_trigger;
        @(posedge mclk) disable iff (!rst_n)
        (chanMode[c] == cct_pkg::CCT_MODE_COMPARE && match) |=> trg_q[c];
      endproperty
      a_trigger: assert property (p_trigger) else $error("trigger missing");

      property p_thr;
        @(posedge mclk) disable iff (!rst_n)
        compareWrite[c] |=> thr_q[c] == $past(compareValue[c]);
      endproperty
      a_thr: assert property (p_thr) else $error("threshold not taken");

      property p_nodead;
        @(posedge mclk) disable iff (!rst_n)
        (rst_n && !useDead) |=> out_q[c] != outN_q[c];
      endproperty
      a_nodead: assert property (p_nodead) else $error("dead time on instance");

      // a pwm level change opens the dead gap
      sequence s_flip;
        useDead && chanMode[c] == cct_pkg::CCT_MODE_PWM && raw_d[c] != raw_q[c];
      endsequence

      property p_dead;
        @(posedge mclk) disable iff (!rst_n)
        s_flip |=> !out_q[c] && !outN_q[c];
      endproperty
      a_dead: assert property (p_dead) else $error("dead gap missing");
    end
  endgenerate

  sequence s_wrap;
    wrap;
  endsequence

  property p_wrap;
    @(posedge mclk) disable iff (!rst_n)
    s_wrap |=> (cnt_q == '0) && ovf_q && ovfPulse_q ##1 !ovfPulse_q || wrap;
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap wrong");

  property p_count;
    @(posedge mclk) disable iff (!rst_n)
    !tick |=> cnt_q == $past(cnt_q);
  endproperty
  a_count: assert property (p_count) else $error("counter moved without tick");

  property p_clear;
    @(posedge mclk) disable iff (!rst_n)
    (overflowClear && !wrap) |=> !ovf_q;
  endproperty
  a_clear: assert property (p_clear) else $error("overflow not cleared");

  assign counterValue   = cnt_q;
  assign overflowFlag   = ovf_q;
  assign captureValue   = cap_q;
  assign captureValid   = capV_q;
  assign chanOut        = out_q;
  assign chanOutN       = outN_q;
  assign reflexTrigger  = trg_q;
  assign reflexOverflow = ovfPulse_q;
endmodule
